/* File: rtl/ebt_timer.sv */
// 8-bit timer channel with clock select, counter clear and ahb-lite regs
`timescale 1ns/1ps
module ebt_timer
    import ebt_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // external pins
    input  wire logic        ext_clock,
    input  wire logic        ext_reset,
    // interrupt requests
    output logic             wrap_irq,
    output logic             match_a_irq,
    output logic             match_b_irq
);

    typedef struct packed {
        logic [7:0]       timer_control;
        logic [7:0]       aux_ctrl;
        logic [7:0]       match_const_a;
        logic [7:0]       match_const_b;
        logic [7:0]       count_value;
        logic             match_a_flag;
        logic             match_b_flag;
        logic             wrap_flag;
        logic             seen_a;
        logic             seen_b;
        logic             seen_w;
        logic [PRE_W-1:0] prescale;
        logic             ext_clk_d;
        logic             ext_rst_d;
        logic             dp_write;
        logic [11:0]      dp_addr;
        logic [31:0]      rdata;
    } ebt_state_s;

    ebt_state_s cur;
    ebt_state_s next_cur;

    logic [2:0] clock_sel;
    logic [1:0] clear_sel;
    logic       aux_prescale_sel;
    logic       tick;
    logic       fall_2;
    logic       fall_8;
    logic       fall_32;
    logic       fall_64;
    logic       fall_256;
    logic       fall_1024;
    logic [PRE_W-1:0] pre_inc;
    logic       ext_rise;
    logic       ext_fall;
    logic       rst_rise;
    logic       match_a;
    logic       match_b;
    logic       do_clear;
    logic [7:0] inc_count;
    logic       addr_ok;
    logic [7:0] wbyte;
    logic [7:0] sts_read;
    logic       sts_rd;
    logic       sts_wr;
    logic       wrap_set;
    logic       next_wrap_flag;
    logic       next_seen_w;
    logic       next_match_a_flag;
    logic       next_seen_a;
    logic       next_match_b_flag;
    logic       next_seen_b;

    assign clock_sel        = cur.timer_control[CTL_CLK_LSB +: 3];
    assign clear_sel        = cur.timer_control[CTL_CLR_LSB +: 2];
    assign aux_prescale_sel = cur.aux_ctrl[AUX_PRESCALE];

    // falling edge of clock/N: bit log2(N)-1 drops on the next increment
    assign pre_inc   = cur.prescale + {{(PRE_W-1){1'b0}}, 1'b1};
    ebt_tap_fall #(.DIV(DIV_2)) u_tap_2 (
        .pre_now  (cur.prescale),
        .pre_next (pre_inc),
        .fall     (fall_2)
    );
    ebt_tap_fall #(.DIV(DIV_8)) u_tap_8 (
        .pre_now  (cur.prescale),
        .pre_next (pre_inc),
        .fall     (fall_8)
    );
    ebt_tap_fall #(.DIV(DIV_32)) u_tap_32 (
        .pre_now  (cur.prescale),
        .pre_next (pre_inc),
        .fall     (fall_32)
    );
    ebt_tap_fall #(.DIV(DIV_64)) u_tap_64 (
        .pre_now  (cur.prescale),
        .pre_next (pre_inc),
        .fall     (fall_64)
    );
    ebt_tap_fall #(.DIV(DIV_256)) u_tap_256 (
        .pre_now  (cur.prescale),
        .pre_next (pre_inc),
        .fall     (fall_256)
    );
    ebt_tap_fall #(.DIV(DIV_1024)) u_tap_1024 (
        .pre_now  (cur.prescale),
        .pre_next (pre_inc),
        .fall     (fall_1024)
    );

    // pin edges against the sample taken one cycle back
    ebt_pin_edge u_ext_clock_edge (
        .pin_now    (ext_clock),
        .pin_before (cur.ext_clk_d),
        .rise       (ext_rise),
        .fall       (ext_fall)
    );
    ebt_pin_edge u_ext_reset_edge (
        .pin_now    (ext_reset),
        .pin_before (cur.ext_rst_d),
        .rise       (rst_rise),
        .fall       ()
    );

    always_comb begin
        unique case (clock_sel)
            CS_STOP0, CS_STOP4: tick = 1'b0;
            CS_DIV_A: tick = aux_prescale_sel ? fall_2 : fall_8;
            CS_DIV_B: tick = aux_prescale_sel ? fall_32 : fall_64;
            CS_DIV_C: tick = aux_prescale_sel ? fall_256
                                              : fall_1024;
            CS_EXT_R: tick = ext_rise;
            CS_EXT_F: tick = ext_fall;
            CS_EXT_B: tick = ext_rise | ext_fall;
        endcase
    end

    assign match_a = (cur.count_value == cur.match_const_a);
    assign match_b = (cur.count_value == cur.match_const_b);

    always_comb begin
        unique case (clear_sel)
            CL_NONE:    do_clear = 1'b0;
            CL_MATCH_A: do_clear = match_a;
            CL_MATCH_B: do_clear = match_b;
            CL_EXT:     do_clear = rst_rise;
        endcase
    end

    assign inc_count = cur.count_value + 8'h01;
    assign addr_ok   = hsel & hready & htrans[1];
    assign wbyte     = hwdata[7:0];
    assign sts_read  = {cur.match_b_flag, cur.match_a_flag, cur.wrap_flag,
                        5'h00};

    // a status read arms in its address phase, the same cycle it samples
    assign sts_rd   = addr_ok & ~hwrite & (haddr == OFS_STATUS);
    assign sts_wr   = cur.dp_write & (cur.dp_addr == OFS_STATUS);
    assign wrap_set = tick & ~do_clear & (cur.count_value == 8'hff);

    ebt_flag_bit u_flag_wrap (
        .flag_now  (cur.wrap_flag),
        .seen_now  (cur.seen_w),
        .set_event (wrap_set),
        .rd_status (sts_rd),
        .wr_status (sts_wr),
        .wr_bit    (wbyte[STS_WRAP]),
        .next_flag (next_wrap_flag),
        .next_seen (next_seen_w)
    );
    ebt_flag_bit u_flag_match_a (
        .flag_now  (cur.match_a_flag),
        .seen_now  (cur.seen_a),
        .set_event (match_a),
        .rd_status (sts_rd),
        .wr_status (sts_wr),
        .wr_bit    (wbyte[STS_MATCHA]),
        .next_flag (next_match_a_flag),
        .next_seen (next_seen_a)
    );
    ebt_flag_bit u_flag_match_b (
        .flag_now  (cur.match_b_flag),
        .seen_now  (cur.seen_b),
        .set_event (match_b),
        .rd_status (sts_rd),
        .wr_status (sts_wr),
        .wr_bit    (wbyte[STS_MATCHB]),
        .next_flag (next_match_b_flag),
        .next_seen (next_seen_b)
    );

    always_comb begin
        next_cur           = cur;
        next_cur.prescale  = pre_inc;
        next_cur.ext_clk_d = ext_clock;
        next_cur.ext_rst_d = ext_reset;
        next_cur.dp_write  = addr_ok & hwrite;
        if (addr_ok) begin
            next_cur.dp_addr = haddr;
        end

        // counter: clear wins over count
        if (do_clear) begin
            next_cur.count_value = 8'h00;
        end else if (tick) begin
            next_cur.count_value = inc_count;
        end

        // software access in the data phase
        if (cur.dp_write) begin
            unique case (cur.dp_addr)
                OFS_CONTROL: next_cur.timer_control = wbyte;
                OFS_AUX:     next_cur.aux_ctrl      = {7'h00, wbyte[0]};
                OFS_CONST_A: next_cur.match_const_a = wbyte;
                OFS_CONST_B: next_cur.match_const_b = wbyte;
                OFS_COUNT:   next_cur.count_value   = wbyte;
                default: ;
            endcase
        end

        // flags and their read-as-one marks come from the flag cells
        next_cur.wrap_flag    = next_wrap_flag;
        next_cur.seen_w       = next_seen_w;
        next_cur.match_a_flag = next_match_a_flag;
        next_cur.seen_a       = next_seen_a;
        next_cur.match_b_flag = next_match_b_flag;
        next_cur.seen_b       = next_seen_b;

        // read data registered for the next data phase
        next_cur.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            unique case (haddr)
                OFS_CONTROL: next_cur.rdata = {24'h0, cur.timer_control};
                OFS_STATUS:  next_cur.rdata = {24'h0, sts_read};
                OFS_CONST_A: next_cur.rdata = {24'h0, cur.match_const_a};
                OFS_CONST_B: next_cur.rdata = {24'h0, cur.match_const_b};
                OFS_COUNT:   next_cur.rdata = {24'h0, cur.count_value};
                OFS_AUX:     next_cur.rdata = {24'h0, cur.aux_ctrl};
                default:     next_cur.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur               <= '0;
            cur.timer_control <= RST_CONTROL;
            cur.aux_ctrl      <= RST_AUX;
            cur.match_const_a <= RST_CONST;
            cur.match_const_b <= RST_CONST;
            cur.count_value   <= RST_COUNT;
        end else begin
            cur <= next_cur;
        end
    end

    assign hrdata    = cur.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign wrap_irq    = cur.wrap_flag
                         & cur.timer_control[CTL_WRAP_IE];
    assign match_a_irq = cur.match_a_flag
                         & cur.timer_control[CTL_MATCHA_IE];
    assign match_b_irq = cur.match_b_flag
                         & cur.timer_control[CTL_MATCHB_IE];
endmodule

// falling edge of one prescaler tap, seen one increment ahead
module ebt_tap_fall
    import ebt_pkg::*;
#(
    parameter int DIV = 2
)
(
    // free counter now and after its next increment
    input  wire logic [PRE_W-1:0] pre_now,
    input  wire logic [PRE_W-1:0] pre_next,
    // one-cycle tick
    output logic                  fall
);
    localparam int TAP = $clog2(DIV) - 1;

    assign fall = pre_now[TAP] & ~pre_next[TAP];
endmodule

// edge pulses of a pin against its sample of the last cycle
module ebt_pin_edge (
    // pin now and one cycle back
    input  wire logic pin_now,
    input  wire logic pin_before,
    // edge pulses
    output logic      rise,
    output logic      fall
);
    assign rise = pin_now & ~pin_before;
    assign fall = ~pin_now & pin_before;
endmodule

// one status flag, set by hardware, cleared by 0 after a read of 1
module ebt_flag_bit (
    // flag and its read-as-one mark
    input  wire logic flag_now,
    input  wire logic seen_now,
    // hardware set event
    input  wire logic set_event,
    // status read in its address phase, write in its data phase
    input  wire logic rd_status,
    input  wire logic wr_status,
    input  wire logic wr_bit,
    // next flag and mark
    output logic      next_flag,
    output logic      next_seen
);
    logic do_clr;

    // a 0 clears only after a read of 1; writing 1 is ignored
    assign do_clr    = wr_status & ~wr_bit & seen_now;
    // hardware set wins over a clear in the same cycle
    assign next_flag = set_event | (flag_now & ~do_clr);
    assign next_seen = ~do_clr & (seen_now | (rd_status & flag_now));
endmodule

/* File: rtl/ebt_pkg.sv */
// package: register map, field positions and prescaler constants of the timer
package ebt_pkg;
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_STATUS  = 12'h004;
    localparam logic [11:0] OFS_CONST_A = 12'h008;
    localparam logic [11:0] OFS_CONST_B = 12'h00c;
    localparam logic [11:0] OFS_COUNT   = 12'h010;
    localparam logic [11:0] OFS_AUX     = 12'h014;

    localparam int CTL_CLK_LSB   = 0;
    localparam int CTL_CLR_LSB   = 3;
    localparam int CTL_WRAP_IE   = 5;
    localparam int CTL_MATCHA_IE = 6;
    localparam int CTL_MATCHB_IE = 7;
    localparam int STS_WRAP      = 5;
    localparam int STS_MATCHA    = 6;
    localparam int STS_MATCHB    = 7;
    localparam int AUX_PRESCALE  = 0;

    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CONST   = 8'hff;
    localparam logic [7:0] RST_COUNT   = 8'h00;
    localparam logic [7:0] RST_AUX     = 8'h00;

    localparam logic [2:0] CS_STOP0 = 3'h0;
    localparam logic [2:0] CS_DIV_A = 3'h1;
    localparam logic [2:0] CS_DIV_B = 3'h2;
    localparam logic [2:0] CS_DIV_C = 3'h3;
    localparam logic [2:0] CS_STOP4 = 3'h4;
    localparam logic [2:0] CS_EXT_R = 3'h5;
    localparam logic [2:0] CS_EXT_F = 3'h6;
    localparam logic [2:0] CS_EXT_B = 3'h7;

    localparam logic [1:0] CL_NONE  = 2'h0;
    localparam logic [1:0] CL_MATCH_A = 2'h1;
    localparam logic [1:0] CL_MATCH_B = 2'h2;
    localparam logic [1:0] CL_EXT   = 2'h3;

    // divide ratios of the prescaler; the falling edge of clock/N
    // lands where bit log2(N)-1 of a free counter goes from 1 to 0
    localparam int PRE_W     = 11;
    localparam int DIV_8     = 8;
    localparam int DIV_2     = 2;
    localparam int DIV_64    = 64;
    localparam int DIV_32    = 32;
    localparam int DIV_1024  = 1024;
    localparam int DIV_256   = 256;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage

/* File: tb/ebt_timer_monitor.sv */
// port assertions of the timer channel
`timescale 1ns/1ps
module ebt_timer_monitor
    import ebt_pkg::*;
(
    // clock, reset and bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // requests
    input wire logic        wrap_irq,
    input wire logic        match_a_irq,
    input wire logic        match_b_irq
);
    logic       take;
    logic [1:0] wr_q;
    assign take = hsel && hready && htrans[1];
    // a write taken two edges back is the only cause of a dropped request
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) wr_q <= 2'h0;
        else wr_q <= {wr_q[0], take && hwrite};
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd;
        take && !hwrite;
    endsequence
    sequence s_rd_sts;
        s_rd ##0 haddr == OFS_STATUS;
    endsequence
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_rd_upper_zero: assert property (s_rd |=> hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_idle_data_zero: assert property (!(take && !hwrite) |=> hrdata == 0)
        else $error("read data not zero without a read");
    a_sts_low_zero: assert property (s_rd_sts |=> hrdata[4:0] == 5'h0)
        else $error("status low bits not zero");
    a_unmapped_zero: assert property (s_rd ##0 haddr > OFS_AUX |=> hrdata == 0)
        else $error("unmapped read not zero");
    a_wrap_fall_write: assert property ($fell(wrap_irq) |-> wr_q[1])
        else $error("wrap request dropped without a write");
    a_match_a_fall: assert property ($fell(match_a_irq) |-> wr_q[1])
        else $error("match a request dropped without a write");
    a_match_b_fall: assert property ($fell(match_b_irq) |-> wr_q[1])
        else $error("match b request dropped without a write");
endmodule
bind ebt_timer ebt_timer_monitor MON (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .wrap_irq,
    .match_a_irq, .match_b_irq);

/* File: tb/ebt_pin_model.sv */
// model of the external count clock and counter reset pins
`timescale 1ns/1ps
module ebt_pin_model (
    // clock
    input  wire logic hclk,
    // pins
    output logic      ext_clock,
    output logic      ext_reset
);
    initial ext_clock = 1'b0;
    initial ext_reset = 1'b0;
    // each level stands two hclk cycles so every pin edge is sampled
    task automatic clk_pulses(input int n);
        repeat (2 * n) begin
            ext_clock <= ~ext_clock;
            repeat (2) @(posedge hclk);
        end
    endtask
    task automatic rst_pulse();
        ext_reset <= 1'b1;
        repeat (2) @(posedge hclk);
        ext_reset <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the timer channel
`timescale 1ns/1ps
module testbench
    import ebt_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        ext_clock, ext_reset, wrap_irq, match_a_irq, match_b_irq;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata, hrdata;
    logic [7:0]  v0, v1;
    int          miscompares, total_checks, cycles;
    ebt_timer DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .ext_clock, .ext_reset, .wrap_irq, .match_a_irq,
        .match_b_irq);
    ebt_pin_model PIN (.hclk, .ext_clock, .ext_reset);
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    // single transfer; read data taken at the edge ending the data phase
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h0, q);
    endtask
    task automatic chk_irq(input string s, input logic [2:0] e);
        @(negedge hclk);
        chk(s, {5'h0, e}, {5'h0, match_b_irq, match_a_irq, wrap_irq});
        @(posedge hclk);
    endtask
    task automatic t_basic();
        logic [11:0] a [7] = '{OFS_CONTROL, OFS_STATUS, OFS_CONST_A,
            OFS_CONST_B, OFS_COUNT, OFS_AUX, 12'h018};
        logic [7:0] e [7] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            rd(a[i], v0);
            chk("reset value", e[i], v0);
        end
        for (int i = 0; i < 2; i++) begin
            wr(OFS_CONTROL, {5'h0, i[0] ? CS_STOP4 : CS_STOP0});
            rd(OFS_COUNT, v0);
            repeat (40) @(posedge hclk);
            rd(OFS_COUNT, v1);
            chk("stopped count", v0, v1);
        end
        $display("test reset and stop done");
    endtask
    // two reads 4N edges apart must see exactly four ticks
    task automatic t_prescale();
        logic [2:0] cs [6] = '{CS_DIV_A, CS_DIV_A, CS_DIV_B, CS_DIV_B,
            CS_DIV_C, CS_DIV_C};
        int n [6] = '{DIV_8, DIV_2, DIV_64, DIV_32, DIV_1024, DIV_256};
        for (int i = 0; i < 6; i++) begin
            wr(OFS_AUX, {7'h0, i[0]});
            wr(OFS_CONTROL, {5'h0, cs[i]});
            rd(OFS_COUNT, v0);
            repeat (4 * n[i] - 2) @(posedge hclk);
            rd(OFS_COUNT, v1);
            chk("prescaled ticks", 8'h04, v1 - v0);
        end
        wr(OFS_CONTROL, 8'h00);
        rd(OFS_STATUS, v0);
        wr(OFS_STATUS, 8'h00);
        wr(OFS_COUNT, 8'hfe);
        wr(OFS_CONTROL, 8'h01);
        repeat (10) @(posedge hclk);
        wr(OFS_CONTROL, 8'h00);
        chk_irq("wrap masked", 3'b000);
        rd(OFS_STATUS, v0);
        chk("wrap flag", 8'h01, {7'h0, v0[STS_WRAP]});
        wr(OFS_CONTROL, 8'h20);
        chk_irq("wrap request", 3'b001);
        $display("test prescaler and wrap done");
    endtask
    task automatic t_ext();
        logic [7:0] e [3] = '{8'h03, 8'h03, 8'h06};
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CONTROL, {5'h0, CS_EXT_R + 3'(i)});
            rd(OFS_COUNT, v0);
            PIN.clk_pulses(3);
            rd(OFS_COUNT, v1);
            chk("pin edges", e[i], v1 - v0);
        end
        wr(OFS_COUNT, 8'h33);
        PIN.rst_pulse();
        rd(OFS_COUNT, v0);
        chk("no clear", 8'h33, v0);
        wr(OFS_CONTROL, 8'h1d);
        PIN.rst_pulse();
        rd(OFS_COUNT, v0);
        chk("pin clear", 8'h00, v0);
        $display("test external pins done");
    endtask
    task automatic t_match(input logic [11:0] ca, input logic [7:0] k,
                           input logic [7:0] ctl, input int sb,
                           input logic [2:0] irq);
        wr(OFS_CONTROL, 8'h00);
        wr(ca, k);
        wr(OFS_COUNT, 8'h00);
        rd(OFS_STATUS, v0);
        wr(OFS_STATUS, 8'h00);
        wr(OFS_CONTROL, ctl);
        PIN.clk_pulses(k + 3);
        wr(OFS_CONTROL, ctl & 8'hc0);
        rd(OFS_COUNT, v0);
        chk("count after match", 8'h03, v0);
        wr(OFS_STATUS, 8'hff);
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, v0);
        chk("match flag", 8'h01, {7'h0, v0[sb]});
        chk_irq("match request", irq);
        wr(OFS_STATUS, 8'h00);
        rd(OFS_STATUS, v0);
        chk("flag cleared", 8'h00, {7'h0, v0[sb]});
        chk_irq("request gone", 3'b000);
        $display("test compare match done");
    endtask
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        {cycles, miscompares, total_checks} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_basic();
        t_prescale();
        t_ext();
        t_match(OFS_CONST_A, 8'h05, 8'h4d, STS_MATCHA, 3'b010);
        t_match(OFS_CONST_B, 8'h04, 8'h95, STS_MATCHB, 3'b100);
        wrap_up();
    end
endmodule
